/* File: src/ncs_map.svh */
// Constants of the NAND command sequencer host controller
// What this block does
// - Page read: setup command, five address cycles, confirm, then wait busy.
// - Column change in output: first command, two column cycles, second command.
// - Software must restart cached or copy sequences when block address changes.
// - Program: data-input command, address, data, confirm; starts on strobe rise.
// - Cached program series ends with ordinary confirm; ready means done.
// - Page copy: copy-read pair, optional data, copy-program pair, final pair.
// - Command latch marks command, address latch address, both low data.
`ifndef NCS_MAP_SVH
`define NCS_MAP_SVH
// Command codes
`define NCS_CMD_READ_SETUP   8'h00
`define NCS_CMD_READ_GO      8'h30
`define NCS_CMD_COL_OUT      8'h05
`define NCS_CMD_COL_OUT_GO   8'hE0
`define NCS_CMD_CACHE_READ   8'h31
`define NCS_CMD_CACHE_LAST   8'h3F
`define NCS_CMD_DATA_IN      8'h80
`define NCS_CMD_PROG_GO      8'h10
`define NCS_CMD_COL_IN       8'h85
`define NCS_CMD_PROG_CACHE   8'h15
`define NCS_CMD_COPY_READ    8'h3A
`define NCS_CMD_COPY_IN      8'h8C
`define NCS_CMD_ERASE_SETUP  8'h60
`define NCS_CMD_ERASE_GO     8'hD0
`define NCS_CMD_STATUS       8'h70
`define NCS_CMD_RESET        8'hFF
// Register byte addresses
`define NCS_ADR_CTRL         8'h00
`define NCS_ADR_ADDR_LO      8'h04
`define NCS_ADR_ADDR_HI      8'h08
`define NCS_ADR_STAT         8'h0C
`define NCS_ADR_WDATA        8'h10
`define NCS_ADR_RDATA        8'h14
`define NCS_ADR_LEN          8'h18
// Control fields
`define NCS_CTRL_OP_LSB      0
`define NCS_CTRL_OP_W        4
`define NCS_CTRL_GO_BIT      8
`define NCS_CTRL_RESET       32'h0000_0000
// Status fields
`define NCS_STAT_BUSY_BIT    0
`define NCS_STAT_RDY_BIT     1
`define NCS_STAT_RVALID_BIT  2
`define NCS_STAT_WREQ_BIT    3
`define NCS_STAT_DEV_LSB     8
// Pin timing, ns and derived cycles at 50 MHz
`define NCS_CLK_NS           20
`define NCS_T_WP_NS          12
`define NCS_T_WH_NS          10
`define NCS_T_WHR_NS         60
`define NCS_T_WB_NS          100
`define NCS_WP_CYC           ((`NCS_T_WP_NS + `NCS_CLK_NS - 1) / `NCS_CLK_NS)
`define NCS_WH_CYC           ((`NCS_T_WH_NS + `NCS_CLK_NS - 1) / `NCS_CLK_NS)
`define NCS_WHR_CYC          ((`NCS_T_WHR_NS + `NCS_CLK_NS - 1) / `NCS_CLK_NS)
`define NCS_WB_CYC           ((`NCS_T_WB_NS + `NCS_CLK_NS - 1) / `NCS_CLK_NS)
`endif

/* File: src/ncs_pkg.sv */
// Types of the NAND command sequencer host controller
package ncs_pkg;
   typedef enum logic [3:0] {
      NCS_OP_READ      = 4'h0,
      NCS_OP_COL_OUT   = 4'h1,
      NCS_OP_CACHE_RD  = 4'h2,
      NCS_OP_CACHE_LST = 4'h3,
      NCS_OP_PROG      = 4'h4,
      NCS_OP_PROG_CA   = 4'h5,
      NCS_OP_COL_IN    = 4'h6,
      NCS_OP_COPY_RD   = 4'h7,
      NCS_OP_COPY_PR   = 4'h8,
      NCS_OP_COPY_LST  = 4'h9,
      NCS_OP_ERASE     = 4'hA,
      NCS_OP_STATUS    = 4'hB,
      NCS_OP_RESET     = 4'hC,
      NCS_OP_RD_BYTES  = 4'hD,
      NCS_OP_WR_BYTES  = 4'hE
   } ncs_op_e;
   typedef enum logic [8:0] {
      NCS_ST_IDLE  = 9'b0_0000_0001,
      NCS_ST_LOAD  = 9'b0_0000_0010,
      NCS_ST_LOW   = 9'b0_0000_0100,
      NCS_ST_HIGH  = 9'b0_0000_1000,
      NCS_ST_WB    = 9'b0_0001_0000,
      NCS_ST_BUSY  = 9'b0_0010_0000,
      NCS_ST_RLOW  = 9'b0_0100_0000,
      NCS_ST_RHIGH = 9'b0_1000_0000,
      NCS_ST_WAITD = 9'b1_0000_0000
   } ncs_state_e;
   typedef enum logic [1:0] {
      NCS_K_CMD  = 2'b01,
      NCS_K_ADDR = 2'b10,
      NCS_K_DATA = 2'b00
   } ncs_kind_e;
endpackage

/* File: src/ncs_step_if.sv */
// Step list link between sequencer and its step table
`timescale 1ns/1ns
`default_nettype none
interface ncs_step_if;
   logic [3:0] op;
   logic [3:0] idx;
   logic [1:0] kind;
   logic [7:0] code;
   logic       last;
   logic       wait_rdy;
   modport seq (output op, output idx, input kind, input code, input last, input wait_rdy);
   modport tab (input op, input idx, output kind, output code, output last, output wait_rdy);
endinterface
`default_nettype wire

/* File: src/ncs_step_rom.sv */
// Step table: cycle kinds and codes of each operation
`timescale 1ns/1ns
`default_nettype none
`include "ncs_map.svh"
module ncs_step_rom
(
   input  wire logic   i_sys_clk,
   ncs_step_if.tab     s
);
   // Step codes: C=command, A=address (code is address byte index), D=data phase marker
   logic [1:0] kind;
   logic [7:0] code;
   logic       last;
   logic       wait_rdy;
   always_ff @(posedge i_sys_clk)
   begin
      s.kind     <= kind;
      s.code     <= code;
      s.last     <= last;
      s.wait_rdy <= wait_rdy;
   end
   always_comb
   begin
      kind     = ncs_pkg::NCS_K_CMD;
      code     = 8'h00;
      last     = 1'b1;
      wait_rdy = 1'b0;
      case (ncs_pkg::ncs_op_e'(s.op))
         ncs_pkg::NCS_OP_READ, ncs_pkg::NCS_OP_COPY_RD:
         begin
            // Setup is sent anyway; harmless even though power-up already holds it
            case (s.idx)
               4'd0: begin code = `NCS_CMD_READ_SETUP; last = 1'b0; end
               4'd1, 4'd2, 4'd3, 4'd4, 4'd5:
               begin kind = ncs_pkg::NCS_K_ADDR; code = 8'(s.idx - 4'd1); last = 1'b0; end
               default:
               begin
                  code = (s.op == 4'(ncs_pkg::NCS_OP_READ)) ? `NCS_CMD_READ_GO : `NCS_CMD_COPY_READ;
                  wait_rdy = 1'b1;
               end
            endcase
         end
         ncs_pkg::NCS_OP_COL_OUT:
         begin
            case (s.idx)
               4'd0: begin code = `NCS_CMD_COL_OUT; last = 1'b0; end
               4'd1, 4'd2: begin kind = ncs_pkg::NCS_K_ADDR; code = 8'(s.idx - 4'd1); last = 1'b0; end
               default: code = `NCS_CMD_COL_OUT_GO;
            endcase
         end
         ncs_pkg::NCS_OP_CACHE_RD: begin code = `NCS_CMD_CACHE_READ; wait_rdy = 1'b1; end
         ncs_pkg::NCS_OP_CACHE_LST: begin code = `NCS_CMD_CACHE_LAST; wait_rdy = 1'b1; end
         ncs_pkg::NCS_OP_PROG, ncs_pkg::NCS_OP_COPY_PR:
         begin
            case (s.idx)
               4'd0:
               begin
                  code = (s.op == 4'(ncs_pkg::NCS_OP_PROG)) ? `NCS_CMD_DATA_IN : `NCS_CMD_COPY_IN;
                  last = 1'b0;
               end
               4'd1, 4'd2, 4'd3, 4'd4, 4'd5:
               begin kind = ncs_pkg::NCS_K_ADDR; code = 8'(s.idx - 4'd1); last = 1'b0; end
               default: begin kind = ncs_pkg::NCS_K_DATA; end
            endcase
         end
         ncs_pkg::NCS_OP_COL_IN:
         begin
            case (s.idx)
               4'd0: begin code = `NCS_CMD_COL_IN; last = 1'b0; end
               4'd1: begin kind = ncs_pkg::NCS_K_ADDR; code = 8'h00; last = 1'b0; end
               4'd2: begin kind = ncs_pkg::NCS_K_ADDR; code = 8'h01; last = 1'b0; end
               default: kind = ncs_pkg::NCS_K_DATA;
            endcase
         end
         ncs_pkg::NCS_OP_PROG_CA: begin code = `NCS_CMD_PROG_CACHE; wait_rdy = 1'b1; end
         ncs_pkg::NCS_OP_COPY_LST, ncs_pkg::NCS_OP_WR_BYTES:
         begin
            if (s.op == 4'(ncs_pkg::NCS_OP_WR_BYTES))
               kind = ncs_pkg::NCS_K_DATA;
            else
            begin
               code = `NCS_CMD_PROG_GO;
               wait_rdy = 1'b1;
            end
         end
         ncs_pkg::NCS_OP_ERASE:
         begin
            case (s.idx)
               4'd0: begin code = `NCS_CMD_ERASE_SETUP; last = 1'b0; end
               4'd1, 4'd2, 4'd3:
               begin kind = ncs_pkg::NCS_K_ADDR; code = 8'(s.idx + 4'd1); last = 1'b0; end
               default: begin code = `NCS_CMD_ERASE_GO; wait_rdy = 1'b1; end
            endcase
         end
         ncs_pkg::NCS_OP_STATUS:
         begin
            case (s.idx)
               4'd0: begin code = `NCS_CMD_STATUS; last = 1'b0; end
               default: kind = ncs_pkg::NCS_K_DATA;
            endcase
         end
         ncs_pkg::NCS_OP_RESET: begin code = `NCS_CMD_RESET; wait_rdy = 1'b1; end
         ncs_pkg::NCS_OP_RD_BYTES: kind = ncs_pkg::NCS_K_DATA;
         default: code = 8'h00;
      endcase
   end
endmodule
`default_nettype wire

/* File: src/ncs_host.sv */
// Host controller top: Wishbone slave plus NAND pin sequencer
//
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "ncs_map.svh"
module ncs_host
#(
   parameter int unsigned BUSY_TIMEOUT = 32'd50000
)
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_srst,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic [31:0]      o_wb_dat,
   output logic             o_wb_ack,
   output logic             o_cmd_latch,
   output logic             o_addr_latch,
   output logic             o_chip_sel_n,
   output logic             o_write_strobe_n,
   output logic             o_read_strobe_n,
   output logic             o_write_prot_n,
   output logic [7:0]       o_io,
   output logic             o_io_oe_n,
   input  wire logic [7:0]  i_io,
   input  wire logic        i_ready_busy_n
);
   ////////////////////////////////////////////////////////////////////////
   // Registers
   logic [3:0]  op;
   logic        go;
   logic [31:0] addr_lo;
   logic [7:0]  addr_hi;
   logic [7:0]  wdata;
   logic        wfull;
   logic [7:0]  rdata;
   logic        rvalid;
   logic [11:0] len;
   logic [11:0] left;
   logic [7:0]  dev_stat;
   logic        tmo;
   logic [3:0]  idx;
   logic [2:0]  tcnt;
   logic [31:0] bcnt;
   logic        fetch;
   ncs_pkg::ncs_state_e state;
   ncs_pkg::ncs_state_e next_state;
   ncs_step_if st();
   ncs_step_rom u_rom
   (
      .i_sys_clk (i_sys_clk),
      .s         (st.tab)
   );
   assign st.op  = op;
   assign st.idx = idx;
   ////////////////////////////////////////////////////////////////////////
   // Bus decode
   wire        wb_req    = i_wb_cyc && i_wb_stb && !o_wb_ack;
   wire        wb_wr     = wb_req && i_wb_we && i_wb_sel[0];
   wire        wr_ctrl   = wb_wr && (i_wb_adr == `NCS_ADR_CTRL);
   wire        wr_alo    = wb_wr && (i_wb_adr == `NCS_ADR_ADDR_LO);
   wire        wr_ahi    = wb_wr && (i_wb_adr == `NCS_ADR_ADDR_HI);
   wire        wr_wdat   = wb_wr && (i_wb_adr == `NCS_ADR_WDATA);
   wire        wr_len    = wb_wr && (i_wb_adr == `NCS_ADR_LEN);
   wire        rd_rdat   = wb_req && !i_wb_we && (i_wb_adr == `NCS_ADR_RDATA);
   wire        idle      = (state == ncs_pkg::NCS_ST_IDLE);
   wire [31:0] stat_word = {16'h0000, dev_stat, 3'b000, tmo, wfull, rvalid, i_ready_busy_n, !idle};
   wire [39:0] addr_all  = {addr_hi, addr_lo};
   wire [7:0]  addr_byte = addr_all[{st.code[2:0], 3'b000} +: 8];
   wire [31:0] rd_mux    = (i_wb_adr == `NCS_ADR_CTRL)    ? {23'h00_0000, go, 4'h0, op} :
                           (i_wb_adr == `NCS_ADR_ADDR_LO) ? addr_lo :
                           (i_wb_adr == `NCS_ADR_ADDR_HI) ? {24'h00_0000, addr_hi} :
                           (i_wb_adr == `NCS_ADR_STAT)    ? stat_word :
                           (i_wb_adr == `NCS_ADR_WDATA)   ? {24'h00_0000, wdata} :
                           (i_wb_adr == `NCS_ADR_RDATA)   ? {24'h00_0000, rdata} :
                           (i_wb_adr == `NCS_ADR_LEN)     ? {20'h0_0000, len} : 32'h0000_0000;
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end
      else
      begin
         o_wb_ack <= wb_req;
         o_wb_dat <= rd_mux;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Software registers
   wire start     = idle && go;
   wire data_step = (st.kind == 2'(ncs_pkg::NCS_K_DATA));
   wire rd_phase  = (op == 4'(ncs_pkg::NCS_OP_STATUS)) || (op == 4'(ncs_pkg::NCS_OP_RD_BYTES));
   wire take_w    = (state == ncs_pkg::NCS_ST_WAITD) && !rd_phase && wfull;
   wire take_r    = (state == ncs_pkg::NCS_ST_RHIGH) && (tcnt == 3'd0);
   // Busy device only hears status and reset; others wait for ready
   wire busy_ok   = (op == 4'(ncs_pkg::NCS_OP_STATUS)) || (op == 4'(ncs_pkg::NCS_OP_RESET)) || i_ready_busy_n;
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         op      <= 4'h0;
         go      <= 1'b0;
         addr_lo <= 32'h0000_0000;
         addr_hi <= 8'h00;
         len     <= 12'h000;
      end
      else
      begin
         if (wr_ctrl)
         begin
            op <= i_wb_dat[`NCS_CTRL_OP_LSB +: `NCS_CTRL_OP_W];
            go <= i_wb_dat[`NCS_CTRL_GO_BIT];
         end
         else if (start && busy_ok)
            go <= 1'b0;
         if (wr_alo)
            addr_lo <= i_wb_dat;
         if (wr_ahi)
            addr_hi <= i_wb_dat[7:0];
         if (wr_len)
            len <= i_wb_dat[11:0];
      end
   end
   // A byte taken in the cycle software writes the next one keeps the new one
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         wdata  <= 8'h00;
         wfull  <= 1'b0;
         rvalid <= 1'b0;
         rdata  <= 8'h00;
      end
      else
      begin
         if (wr_wdat)
         begin
            wdata <= i_wb_dat[7:0];
            wfull <= 1'b1;
         end
         else if (take_w)
            wfull <= 1'b0;
         if (take_r)
         begin
            rdata  <= i_io;
            rvalid <= 1'b1;
         end
         else if (rd_rdat)
            rvalid <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Pin sequencer
   wire tdone    = (tcnt == 3'd0);
   wire last_b   = (left == 12'd1);
   always_comb
   begin
      next_state = state;
      case (state)
         ncs_pkg::NCS_ST_IDLE:  if (start && busy_ok) next_state = ncs_pkg::NCS_ST_LOAD;
         ncs_pkg::NCS_ST_LOAD:  if (!fetch) next_state = data_step ? ncs_pkg::NCS_ST_WAITD : ncs_pkg::NCS_ST_LOW;
         ncs_pkg::NCS_ST_LOW:   if (tdone) next_state = ncs_pkg::NCS_ST_HIGH;
         ncs_pkg::NCS_ST_HIGH:
            if (tdone)
            begin
               if (data_step && (last_b || len == 12'd0))
                  next_state = ncs_pkg::NCS_ST_IDLE;
               else if (data_step)
                  next_state = ncs_pkg::NCS_ST_WAITD;
               else if (st.last)
                  next_state = st.wait_rdy ? ncs_pkg::NCS_ST_WB : ncs_pkg::NCS_ST_IDLE;
               else
                  next_state = ncs_pkg::NCS_ST_LOAD;
            end
         ncs_pkg::NCS_ST_WB:    if (tdone) next_state = ncs_pkg::NCS_ST_BUSY;
         ncs_pkg::NCS_ST_BUSY:  if (i_ready_busy_n || tmo) next_state = ncs_pkg::NCS_ST_IDLE;
         ncs_pkg::NCS_ST_WAITD:
            if (len == 12'd0)
               next_state = ncs_pkg::NCS_ST_IDLE;
            else if (rd_phase && !rvalid && tdone)
               next_state = ncs_pkg::NCS_ST_RLOW;
            else if (take_w)
               next_state = ncs_pkg::NCS_ST_LOW;
         ncs_pkg::NCS_ST_RLOW:  if (tdone) next_state = ncs_pkg::NCS_ST_RHIGH;
         ncs_pkg::NCS_ST_RHIGH: next_state = (last_b) ? ncs_pkg::NCS_ST_IDLE : ncs_pkg::NCS_ST_WAITD;
         default:               next_state = ncs_pkg::NCS_ST_IDLE;
      endcase
   end
   wire enter_low = (next_state == ncs_pkg::NCS_ST_LOW) && (state != ncs_pkg::NCS_ST_LOW);
   wire enter_rlo = (next_state == ncs_pkg::NCS_ST_RLOW) && (state != ncs_pkg::NCS_ST_RLOW);
   wire enter_hi  = (next_state == ncs_pkg::NCS_ST_HIGH) && (state != ncs_pkg::NCS_ST_HIGH);
   wire enter_wb  = (next_state == ncs_pkg::NCS_ST_WB) && (state != ncs_pkg::NCS_ST_WB);
   wire first_rd  = (state == ncs_pkg::NCS_ST_LOAD) && (next_state == ncs_pkg::NCS_ST_WAITD);
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         state <= ncs_pkg::NCS_ST_IDLE;
         idx   <= 4'h0;
         fetch <= 1'b0;
         tcnt  <= 3'd0;
         left  <= 12'h000;
      end
      else
      begin
         state <= next_state;
         fetch <= (next_state == ncs_pkg::NCS_ST_LOAD) && (state != ncs_pkg::NCS_ST_LOAD);
         if (next_state == ncs_pkg::NCS_ST_IDLE)
            idx <= 4'h0;
         else if ((state == ncs_pkg::NCS_ST_HIGH) && (next_state == ncs_pkg::NCS_ST_LOAD))
            idx <= idx + 4'h1;
         if (first_rd)
            left <= len;
         else if (take_r || ((state == ncs_pkg::NCS_ST_HIGH) && data_step && tdone))
            left <= left - 12'd1;
         if (enter_low || enter_rlo)
            tcnt <= 3'(`NCS_WP_CYC - 1);
         else if (enter_hi)
            tcnt <= 3'(`NCS_WH_CYC - 1);
         else if (enter_wb)
            tcnt <= 3'(`NCS_WB_CYC - 1);
         else if (first_rd)
            tcnt <= 3'(`NCS_WHR_CYC);
         else if (!tdone)
            tcnt <= tcnt - 3'd1;
      end
   end
   // Busy watchdog: a stuck busy line ends the wait instead of hanging software
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst || start)
      begin
         bcnt <= 32'h0000_0000;
         tmo  <= 1'b0;
      end
      else if (state == ncs_pkg::NCS_ST_BUSY && !i_ready_busy_n)
      begin
         bcnt <= bcnt + 32'h0000_0001;
         if (bcnt >= BUSY_TIMEOUT)
            tmo <= 1'b1;
      end
   end
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
         dev_stat <= 8'h00;
      else if (take_r && op == 4'(ncs_pkg::NCS_OP_STATUS))
         dev_stat <= i_io;
   end
   ////////////////////////////////////////////////////////////////////////
   // Pins
   wire in_cycle = (next_state == ncs_pkg::NCS_ST_LOW) || (next_state == ncs_pkg::NCS_ST_HIGH);
   wire we_low   = (next_state == ncs_pkg::NCS_ST_LOW);
   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         o_cmd_latch      <= 1'b0;
         o_addr_latch     <= 1'b0;
         o_chip_sel_n     <= 1'b1;
         o_write_strobe_n <= 1'b1;
         o_read_strobe_n  <= 1'b1;
         o_write_prot_n   <= 1'b0;
         o_io             <= 8'h00;
         o_io_oe_n        <= 1'b1;
      end
      else
      begin
         o_write_prot_n   <= 1'b1;
         o_chip_sel_n     <= (next_state == ncs_pkg::NCS_ST_IDLE);
         o_cmd_latch      <= in_cycle && (st.kind == 2'(ncs_pkg::NCS_K_CMD));
         o_addr_latch     <= in_cycle && (st.kind == 2'(ncs_pkg::NCS_K_ADDR));
         o_write_strobe_n <= !we_low;
         o_read_strobe_n  <= !(next_state == ncs_pkg::NCS_ST_RLOW);
         o_io_oe_n        <= !in_cycle;
         if (state == ncs_pkg::NCS_ST_LOAD || take_w)
            o_io <= data_step ? wdata : (st.kind == 2'(ncs_pkg::NCS_K_ADDR)) ? addr_byte : st.code;
      end
   end
   // Block-address changes need software to restart cached and copy series
   // Device-side work is seen only as busy time
endmodule
`default_nettype wire

/* File: testbench/ncs_host_assertions.sv */
// Pin and bus assertions of the flash host controller
`timescale 1ns/1ns
`default_nettype none
module ncs_host_assertions
#(
   parameter int unsigned BUSY_TIMEOUT = 32'd50000
)
(
   input wire logic       i_sys_clk,
   input wire logic       i_srst,
   input wire logic       i_wb_cyc,
   input wire logic       i_wb_stb,
   input wire logic       o_wb_ack,
   input wire logic       o_cmd_latch,
   input wire logic       o_addr_latch,
   input wire logic       o_chip_sel_n,
   input wire logic       o_write_strobe_n,
   input wire logic       o_read_strobe_n,
   input wire logic [7:0] o_io,
   input wire logic       o_io_oe_n,
   input wire logic       i_ready_busy_n
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);
   ack_one_cycle_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
      else $error("bus answer timing wrong");
   idle_after_reset_a: assert property ($fell(i_srst) |-> o_chip_sel_n && o_write_strobe_n
      && o_read_strobe_n && !o_cmd_latch && !o_addr_latch && o_io_oe_n) else $error("pins not idle");
   latch_exclusive_a: assert property (!(o_cmd_latch && o_addr_latch))
      else $error("both latches high");
   strobe_selected_a: assert property (!o_write_strobe_n || !o_read_strobe_n |-> !o_chip_sel_n)
      else $error("strobe without select");
   write_pulse_a: assert property ($fell(o_write_strobe_n) |=> $rose(o_write_strobe_n))
      else $error("write pulse width wrong");
   hold_at_rise_a: assert property ($rose(o_write_strobe_n) |-> $stable(o_io) && $stable(o_cmd_latch))
      else $error("byte changed at strobe rise");
   host_drives_a: assert property (!o_write_strobe_n |-> !o_io_oe_n)
      else $error("write strobe with bus released");
   bus_released_a: assert property (!o_read_strobe_n |-> o_io_oe_n && !o_cmd_latch && !o_addr_latch)
      else $error("read strobe while driving");
   busy_gate_a: assert property (!o_write_strobe_n && !i_ready_busy_n |-> o_cmd_latch
      && (o_io == 8'h70 || o_io == 8'hFF)) else $error("write while device busy");
   prog_seen_c: cover property (!o_write_strobe_n && o_cmd_latch && o_io == 8'h10);
   read_seen_c: cover property ($fell(o_read_strobe_n));
   busy_seen_c: cover property ($fell(i_ready_busy_n));
endmodule
bind ncs_host ncs_host_assertions #(.BUSY_TIMEOUT(BUSY_TIMEOUT)) ncs_host_assertions_inst (.i_sys_clk(i_sys_clk),
   .i_srst(i_srst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .o_cmd_latch(o_cmd_latch),
   .o_addr_latch(o_addr_latch), .o_chip_sel_n(o_chip_sel_n), .o_write_strobe_n(o_write_strobe_n),
   .o_read_strobe_n(o_read_strobe_n), .o_io(o_io), .o_io_oe_n(o_io_oe_n), .i_ready_busy_n(i_ready_busy_n));
`default_nettype wire

/* File: testbench/ncs_dev_model.sv */
// Behavioural flash device on the far side of the host controller
`timescale 1ns/1ns
`default_nettype none
module ncs_dev_model
#(
   parameter int BUSY_NS = 400
)
(
   input  wire logic       i_cmd_latch,
   input  wire logic       i_addr_latch,
   input  wire logic       i_chip_sel_n,
   input  wire logic       i_write_strobe_n,
   input  wire logic       i_read_strobe_n,
   input  wire logic [7:0] i_io,
   output logic [7:0]      o_io,
   output logic            o_ready_busy_n
);
   logic [7:0] mem [int];
   int         na;
   int         col;
   int         row;
   int         rr;
   bit         stat;
   initial
   begin
      o_io = 8'h00;
      o_ready_busy_n = 1'b1;
   end
   task automatic busy;
      #90 o_ready_busy_n = 1'b0; // Near the limit, so the host must really wait
      #(BUSY_NS) o_ready_busy_n = 1'b1;
   endtask
   always @(posedge i_write_strobe_n)
   begin
      if (!i_chip_sel_n && i_cmd_latch && (o_ready_busy_n || i_io == 8'h70 || i_io == 8'hFF))
      begin
         stat = (i_io == 8'h70);
         na = 0;
         if (i_io inside {8'h30, 8'h3A, 8'h31, 8'h3F})
            rr = row;
         if (i_io == 8'h31)
            row++;
         if (i_io == 8'h31 || i_io == 8'h3F)
            col = 0;
         if (i_io inside {8'h30, 8'h31, 8'h3F, 8'h3A, 8'h10, 8'h15, 8'hD0, 8'hFF})
            fork busy(); join_none
      end
      else if (!i_chip_sel_n && !i_cmd_latch && o_ready_busy_n && i_addr_latch)
      begin
         if (na < 2)
            col[8*na +: 8] = i_io;
         else
            row[8*(na-2) +: 8] = i_io;
         na++;
      end
      else if (!i_chip_sel_n && !i_cmd_latch && o_ready_busy_n)
      begin
         mem[row*4096+col] = i_io;
         col++;
      end
   end
   always @(negedge i_read_strobe_n)
   begin
      if (!i_chip_sel_n)
      begin
         o_io <= #15 stat ? {1'b0, o_ready_busy_n, o_ready_busy_n, 5'h00}
            : (mem.exists(rr*4096+col) ? mem[rr*4096+col] : 8'(rr*3+col));
         if (!stat)
            col++;
      end
   end
   // No pull on the bus: after release show a changing value
   always @(posedge i_read_strobe_n)
      o_io <= #22 ~o_io;
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench of the flash host controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic i_sys_clk = 1'b0, i_srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00, io_o, io_i;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic ack, cl, al, cs_n, ws_n, rs_n, oe_n, rb_n, wp_n;
   int n_mismatch = 0, n_compared = 0;
   ncs_host #(.BUSY_TIMEOUT(200)) ncs_host_inst (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat),
      .o_wb_ack(ack), .o_cmd_latch(cl), .o_addr_latch(al), .o_chip_sel_n(cs_n), .o_write_strobe_n(ws_n),
      .o_read_strobe_n(rs_n), .o_write_prot_n(wp_n), .o_io(io_o), .o_io_oe_n(oe_n), .i_io(io_i),
      .i_ready_busy_n(rb_n));
   ncs_dev_model ncs_dev_model_inst (.i_cmd_latch(cl), .i_addr_latch(al), .i_chip_sel_n(cs_n),
      .i_write_strobe_n(ws_n), .i_read_strobe_n(rs_n), .i_io(io_o), .o_io(io_i), .o_ready_busy_n(rb_n));
   initial
   begin
      forever #10 i_sys_clk = ~i_sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   // Entered just after a clock edge; holds the request until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge i_sys_clk); while (ack !== 1'b1 && ++t < 50);
      if (t >= 50)
         n_mismatch++;
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge i_sys_clk);
   endtask
   task automatic poll(input int b, input logic v);
      int t;
      t = 0;
      do wb(1'b0, 8'h0C, 32'h0); while (q[b] !== v && ++t < 3000);
      if (t >= 3000)
         n_mismatch++;
   endtask
   task automatic op(input ncs_pkg::ncs_op_e o, input logic [7:0] len, input logic fin);
      wb(1'b1, 8'h18, {24'h0, len});
      wb(1'b1, 8'h00, {23'h0, 1'b1, 4'h0, o});
      if (fin)
         poll(0, 1'b0);
   endtask
   task automatic put(input logic [7:0] d);
      wb(1'b1, 8'h10, {24'h0, d});
      poll(3, 1'b0);
   endtask
   task automatic get(input string n, input logic [7:0] e);
      poll(2, 1'b1);
      wb(1'b0, 8'h14, 32'h0);
      chk(n, {24'h0, e}, {24'h0, q[7:0]});
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (6) @(posedge i_sys_clk);
      i_srst <= 1'b0;
      @(posedge i_sys_clk);
      wb(1'b0, 8'h0C, 32'h0);
      chk("stat_idle", 32'h2, q & 32'h3);
      chk("write_prot", 32'h1, {31'h0, wp_n});
      wb(1'b0, 8'h1C, 32'h0);
      chk("unmapped", 32'h0, q);
      wb(1'b1, 8'h04, 32'h0005_0002);
      wb(1'b1, 8'h08, 32'h0);
      op(ncs_pkg::NCS_OP_PROG, 8'h02, 1'b0);
      put(8'hA5);
      put(8'h3C);
      poll(0, 1'b0);
      wb(1'b1, 8'h04, 32'h0005_0010);
      op(ncs_pkg::NCS_OP_COL_IN, 8'h01, 1'b0);
      put(8'h77);
      poll(0, 1'b0);
      op(ncs_pkg::NCS_OP_PROG_CA, 8'h00, 1'b1);
      wb(1'b1, 8'h04, 32'h0007_0000);
      op(ncs_pkg::NCS_OP_PROG, 8'h00, 1'b1);
      op(ncs_pkg::NCS_OP_COPY_LST, 8'h00, 1'b1);
      op(ncs_pkg::NCS_OP_STATUS, 8'h01, 1'b0);
      get("status", 8'h60);
      wb(1'b1, 8'h04, 32'h0005_0002);
      op(ncs_pkg::NCS_OP_READ, 8'h00, 1'b1);
      op(ncs_pkg::NCS_OP_RD_BYTES, 8'h02, 1'b0);
      get("read_b0", 8'hA5);
      get("read_b1", 8'h3C);
      wb(1'b1, 8'h04, 32'h0005_0010);
      op(ncs_pkg::NCS_OP_COL_OUT, 8'h00, 1'b1);
      op(ncs_pkg::NCS_OP_RD_BYTES, 8'h01, 1'b0);
      get("col_out", 8'h77);
      op(ncs_pkg::NCS_OP_CACHE_RD, 8'h00, 1'b1);
      op(ncs_pkg::NCS_OP_RD_BYTES, 8'h01, 1'b0);
      get("cache_rd", 8'h0F);
      op(ncs_pkg::NCS_OP_CACHE_LST, 8'h00, 1'b1);
      op(ncs_pkg::NCS_OP_RD_BYTES, 8'h01, 1'b0);
      get("cache_last", 8'h12);
      op(ncs_pkg::NCS_OP_COPY_RD, 8'h00, 1'b1);
      wb(1'b1, 8'h04, 32'h0009_0000);
      op(ncs_pkg::NCS_OP_COPY_PR, 8'h00, 1'b1);
      op(ncs_pkg::NCS_OP_COPY_LST, 8'h00, 1'b1);
      op(ncs_pkg::NCS_OP_ERASE, 8'h00, 1'b1);
      op(ncs_pkg::NCS_OP_RESET, 8'h00, 1'b1);
      wb(1'b0, 8'h0C, 32'h0);
      chk("stat_end", 32'h6002, q & 32'hFF03);
      end_of_test();
   end
   initial
   begin
      #2_000_000;
      n_mismatch++;
      end_of_test();
   end
endmodule
`default_nettype wire
